/* hw/fpz_preproc.sv */
// Local design decisions: the address-and-strobe port and the placing of the registers.
module fpz_preproc (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              sys_rst_i,
  // Register port
  input  wire logic [fpz_pkg::ADDR_W-1:0]        reg_addr_i,
  input  wire logic [fpz_pkg::DATA_W-1:0]        reg_wdata_i,
  input  wire logic                              reg_write_i,
  input  wire logic                              reg_read_i,
  output logic [fpz_pkg::DATA_W-1:0]             reg_rdata_o,
  // Samples from the input formatter
  input  wire logic                              in_valid_i,
  output logic                                   in_ready_o,
  input  wire logic [fpz_pkg::SAMPLE_W-1:0]      in_real_i,
  input  wire logic [fpz_pkg::SAMPLE_W-1:0]      in_imag_i,
  // Samples to the windowing stage
  output logic                                   out_valid_o,
  input  wire logic                              out_ready_i,
  output logic [fpz_pkg::SAMPLE_W-1:0]           out_real_o,
  output logic [fpz_pkg::SAMPLE_W-1:0]           out_imag_o,
  // Stage enables for the chained stages
  output logic                                   window_enable_o,
  output logic                                   fft_enable_o,
  output logic                                   logmag_enable_o
);
  localparam int SW = fpz_pkg::SAMPLE_W;
  localparam int PW = fpz_pkg::PHASE_W;
  localparam int CW = fpz_pkg::COUNT_W;

  // Saturating complex product, shifted right by a variable amount
  function automatic logic [2*SW-1:0] cmul(input logic signed [SW-1:0] ar, input logic signed [SW-1:0] ai,
                                           input logic signed [SW-1:0] br, input logic signed [SW-1:0] bi,
                                           input logic [5:0] sh);
    logic signed [2*SW:0]   pr, pi;
    logic signed [2*SW:0]   hr, hi;
    logic signed [SW-1:0]   yr, yi;
    pr = (2*SW+1)'(ar * br) - (2*SW+1)'(ai * bi);
    pi = (2*SW+1)'(ar * bi) + (2*SW+1)'(ai * br);
    hr = pr >>> sh;
    hi = pi >>> sh;
    yr = sat(hr);
    yi = sat(hi);
    return {yr, yi};
  endfunction

  // Clamp a wide value into the sample range
  function automatic logic signed [SW-1:0] sat(input logic signed [2*SW:0] v);
    logic signed [2*SW:0] hi_lim, lo_lim;
    hi_lim = (2*SW+1)'((1 << (SW-1)) - 1);
    lo_lim = -(2*SW+1)'(1 << (SW-1));
    if (v > hi_lim) begin
      return SW'(hi_lim);
    end else if (v < lo_lim) begin
      return SW'(lo_lim);
    end
    return SW'(v);
  endfunction

  // Absolute value of a signed sample, one bit wider
  function automatic logic [SW-1:0] absv(input logic signed [SW-1:0] v);
    logic signed [SW:0] w;
    w = (SW+1)'(v);
    return (w < 0) ? SW'(-w) : SW'(w);
  endfunction

  // Control and configuration state
  logic                      pre_en_reg, pre_en_next;
  logic                      win_en_reg, win_en_next;
  logic                      fft_en_reg, fft_en_next;
  logic                      log_en_reg, log_en_next;
  logic                      zero_en_reg, zero_en_next;
  fpz_pkg::fpz_mode_t        mode_reg, mode_next;
  logic [fpz_pkg::SIZE_W-1:0] size_reg, size_next;
  logic [SW-1:0]             thresh_reg, thresh_next;
  logic [PW-1:0]             step_reg, step_next;
  logic [CW-1:0]             count_reg, count_next;
  logic [fpz_pkg::SCALE_W-1:0] scale_i_reg, scale_i_next;
  logic [fpz_pkg::SCALE_W-1:0] scale_q_reg, scale_q_next;
  logic [fpz_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  // Stream state
  logic [PW-1:0]             freq_reg, freq_next;
  logic [PW-1:0]             index_reg, index_next;
  logic [CW-1:0]             n_reg, n_next;
  logic [15:0]               zcnt_reg, zcnt_next;
  logic                      s1_valid_reg, s1_valid_next;
  logic [SW-1:0]             s1_re_reg, s1_re_next, s1_im_reg, s1_im_next;
  logic                      s2_valid_reg, s2_valid_next;
  logic [SW-1:0]             s2_re_reg, s2_re_next, s2_im_reg, s2_im_next;
  // Combinational helpers
  logic                      adv, take, start, fifo_in_ready;
  logic [SW-1:0]             mag, mx, mn;
  logic [SW+1:0]             est;
  logic                      zero_hit;
  logic signed [fpz_pkg::TWID_W-1:0] tw_cos, tw_sin;
  logic [2*SW-1:0]           prod;
  logic [2*SW-1:0]           fifo_out;

  assign start = reg_write_i && (reg_addr_i == fpz_pkg::CTRL_OFS) && reg_wdata_i[fpz_pkg::CTRL_START_BIT];

  // Stall only when the FIFO cannot take the last stage's sample
  assign adv        = !s2_valid_reg || fifo_in_ready;
  assign in_ready_o = adv;
  assign take       = in_valid_i && adv;

  // magnitude approximation
  // max(max, 7/8*max + 1/2*min) on absolute parts; stays under 2^24
  always_comb begin
    mx  = (absv(in_real_i) > absv(in_imag_i)) ? absv(in_real_i) : absv(in_imag_i);
    mn  = (absv(in_real_i) > absv(in_imag_i)) ? absv(in_imag_i) : absv(in_real_i);
    est = (SW+2)'(mx) - (SW+2)'(mx >> 3) + (SW+2)'(mn >> 1);
    mag = (est > (SW+2)'(mx)) ? SW'(est) : mx;
  end

  // per-set gate; an all-ones threshold never fires
  assign zero_hit = pre_en_reg && zero_en_reg && (mag > thresh_reg);

  // Register writes and the one-cycle-late read data
  always_comb begin
    pre_en_next  = pre_en_reg;
    win_en_next  = win_en_reg;
    fft_en_next  = fft_en_reg;
    log_en_next  = log_en_reg;
    zero_en_next = zero_en_reg;
    mode_next    = mode_reg;
    size_next    = size_reg;
    thresh_next  = thresh_reg;
    step_next    = step_reg;
    count_next   = count_reg;
    scale_i_next = scale_i_reg;
    scale_q_next = scale_q_reg;
    rdata_next   = '0;
    if (reg_write_i) begin
      case (reg_addr_i)
        fpz_pkg::CTRL_OFS: begin
          pre_en_next  = reg_wdata_i[fpz_pkg::CTRL_PRE_BIT];
          win_en_next  = reg_wdata_i[fpz_pkg::CTRL_WIN_BIT];
          fft_en_next  = reg_wdata_i[fpz_pkg::CTRL_FFT_BIT];
          log_en_next  = reg_wdata_i[fpz_pkg::CTRL_LOG_BIT];
          zero_en_next = reg_wdata_i[fpz_pkg::CTRL_ZERO_BIT];
          mode_next    = fpz_pkg::fpz_mode_t'(reg_wdata_i[fpz_pkg::CTRL_MODE_LSB +: 3]);
          size_next    = reg_wdata_i[fpz_pkg::CTRL_SIZE_LSB +: fpz_pkg::SIZE_W];
        end
        fpz_pkg::THRESH_OFS: thresh_next = reg_wdata_i[SW-1:0];
        fpz_pkg::STEP_OFS:   step_next   = reg_wdata_i[PW-1:0];
        fpz_pkg::COUNT_OFS:  count_next  = reg_wdata_i[CW-1:0];
        fpz_pkg::SCALEI_OFS: scale_i_next = reg_wdata_i[fpz_pkg::SCALE_W-1:0];
        fpz_pkg::SCALEQ_OFS: scale_q_next = reg_wdata_i[fpz_pkg::SCALE_W-1:0];
        default: ;
      endcase
    end
    if (reg_read_i) begin
      case (reg_addr_i)
        fpz_pkg::CTRL_OFS: begin
          rdata_next[fpz_pkg::CTRL_PRE_BIT]  = pre_en_reg;
          rdata_next[fpz_pkg::CTRL_WIN_BIT]  = win_en_reg;
          rdata_next[fpz_pkg::CTRL_FFT_BIT]  = fft_en_reg;
          rdata_next[fpz_pkg::CTRL_LOG_BIT]  = log_en_reg;
          rdata_next[fpz_pkg::CTRL_ZERO_BIT] = zero_en_reg;
          rdata_next[fpz_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
          rdata_next[fpz_pkg::CTRL_SIZE_LSB +: fpz_pkg::SIZE_W] = size_reg;
        end
        fpz_pkg::THRESH_OFS: rdata_next[SW-1:0] = thresh_reg;
        fpz_pkg::STEP_OFS:   rdata_next[PW-1:0] = step_reg;
        fpz_pkg::COUNT_OFS:  rdata_next[CW-1:0] = count_reg;
        fpz_pkg::SCALEI_OFS: rdata_next[fpz_pkg::SCALE_W-1:0] = scale_i_reg;
        fpz_pkg::SCALEQ_OFS: rdata_next[fpz_pkg::SCALE_W-1:0] = scale_q_reg;
        fpz_pkg::STATUS_OFS: begin
          rdata_next[CW-1:0] = n_reg;
          rdata_next[fpz_pkg::STAT_INDEX_LSB +: PW] = index_reg;
        end
        fpz_pkg::ZCOUNT_OFS: rdata_next[15:0] = zcnt_reg;
        default: ;
      endcase
    end
  end

  // Phase walk across one iteration of count+1 samples
  always_comb begin
    freq_next  = freq_reg;
    index_next = index_reg;
    n_next     = n_reg;
    zcnt_next  = zcnt_reg;
    if (start) begin
      freq_next  = step_next;
      index_next = '0;
      n_next     = '0;
      zcnt_next  = '0;
    end else if (take) begin
      if (zero_hit) begin
        zcnt_next = zcnt_reg + 1'b1;
      end
      if (n_reg == count_reg) begin
        // Iteration ends: phase restarts at sample zero
        n_next     = '0;
        index_next = '0;
        // DFT mode steps the frequency by 2^(14-size)
        if (mode_reg == fpz_pkg::MODE_DFT) begin
          freq_next = freq_reg + PW'(1 << (PW - int'(size_reg)));
        end
      end else begin
        n_next = n_reg + 1'b1;
        index_next = index_reg + freq_reg;
      end
    end
  end

  // twiddle lookup, aligned with stage one
  fpz_twiddle u_twiddle (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .hold_i    (!adv),
    .index_i   (index_reg),
    .cos_o     (tw_cos),
    .sin_o     (tw_sin)
  );

  // stage one holds the zeroed sample
  always_comb begin
    s1_valid_next = s1_valid_reg;
    s1_re_next    = s1_re_reg;
    s1_im_next    = s1_im_reg;
    if (adv) begin
      s1_valid_next = in_valid_i;
      s1_re_next    = zero_hit ? '0 : in_real_i;
      s1_im_next    = zero_hit ? '0 : in_imag_i;
    end
  end

  // mode selection
  // Stitch and vector modes are handled outside this block and pass through
  always_comb begin
    case (mode_reg)
      fpz_pkg::MODE_FSHIFT, fpz_pkg::MODE_DFT:
        prod = cmul(s1_re_reg, s1_im_reg, SW'(tw_cos), SW'(tw_sin), 6'(fpz_pkg::TWID_FRAC));
      fpz_pkg::MODE_MAGSQ:
        prod = cmul(s1_re_reg, s1_im_reg, s1_re_reg, -s1_im_reg, 6'(fpz_pkg::MAGSQ_SHIFT));
      fpz_pkg::MODE_SCALAR:
        prod = cmul(s1_re_reg, s1_im_reg, SW'($signed(scale_i_reg)), SW'($signed(scale_q_reg)),
                    6'(fpz_pkg::SCALE_FRAC));
      default:
        prod = {s1_re_reg, s1_im_reg};
    endcase
  end

  // bypass when mode is zero or stage disabled
  always_comb begin
    s2_valid_next = s2_valid_reg;
    s2_re_next    = s2_re_reg;
    s2_im_next    = s2_im_reg;
    if (adv) begin
      s2_valid_next = s1_valid_reg;
      if (pre_en_reg && (mode_reg != fpz_pkg::MODE_BYPASS)) begin
        s2_re_next = prod[2*SW-1:SW];
        s2_im_next = prod[SW-1:0];
      end else begin
        s2_re_next = s1_re_reg;
        s2_im_next = s1_im_reg;
      end
    end
  end

  // output feeds the next stage through the FIFO
  fpz_fifo #(
    .WIDTH (2*SW),
    .DEPTH (fpz_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (s2_valid_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({s2_re_reg, s2_im_reg}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_out)
  );

  assign out_real_o      = fifo_out[2*SW-1:SW];
  assign out_imag_o      = fifo_out[SW-1:0];
  assign window_enable_o = win_en_reg;
  assign fft_enable_o    = fft_en_reg;
  assign logmag_enable_o = log_en_reg;
  assign reg_rdata_o     = rdata_reg;

  // State registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_en_reg   <= 1'b0;
      win_en_reg   <= 1'b0;
      fft_en_reg   <= 1'b0;
      log_en_reg   <= 1'b0;
      zero_en_reg  <= 1'b0;
      mode_reg     <= fpz_pkg::MODE_BYPASS;
      size_reg     <= '0;
      thresh_reg   <= fpz_pkg::THRESH_RST;
      step_reg     <= '0;
      count_reg    <= '0;
      scale_i_reg  <= fpz_pkg::SCALE_RST;
      scale_q_reg  <= '0;
      rdata_reg    <= '0;
      freq_reg     <= '0;
      index_reg    <= '0;
      n_reg        <= '0;
      zcnt_reg     <= '0;
      s1_valid_reg <= 1'b0;
      s1_re_reg    <= '0;
      s1_im_reg    <= '0;
      s2_valid_reg <= 1'b0;
      s2_re_reg    <= '0;
      s2_im_reg    <= '0;
    end else begin
      pre_en_reg   <= pre_en_next;
      win_en_reg   <= win_en_next;
      fft_en_reg   <= fft_en_next;
      log_en_reg   <= log_en_next;
      zero_en_reg  <= zero_en_next;
      mode_reg     <= mode_next;
      size_reg     <= size_next;
      thresh_reg   <= thresh_next;
      step_reg     <= step_next;
      count_reg    <= count_next;
      scale_i_reg  <= scale_i_next;
      scale_q_reg  <= scale_q_next;
      rdata_reg    <= rdata_next;
      freq_reg     <= freq_next;
      index_reg    <= index_next;
      n_reg        <= n_next;
      zcnt_reg     <= zcnt_next;
      s1_valid_reg <= s1_valid_next;
      s1_re_reg    <= s1_re_next;
      s1_im_reg    <= s1_im_next;
      s2_valid_reg <= s2_valid_next;
      s2_re_reg    <= s2_re_next;
      s2_im_reg    <= s2_im_next;
    end
  end
endmodule

/* hw/fpz_pkg.sv */
package fpz_pkg;
  // Sample and arithmetic widths
  localparam int SAMPLE_W    = 24;
  localparam int TWID_W      = 18;
  localparam int SCALE_W     = 21;
  localparam int PHASE_W     = 14;
  localparam int COUNT_W     = 12;
  localparam int SIZE_W      = 4;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int FIFO_DEPTH  = 4;
  // Twiddle table: quarter wave of a 16384 point circle
  localparam int TWID_POINTS = 16384;
  localparam int QUARTER     = 4096;
  localparam int QUARTER_W   = 12;
  localparam int TWID_FRAC   = 16;
  localparam int SCALE_FRAC  = 16;
  localparam int MAGSQ_SHIFT = 23;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] THRESH_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STEP_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] SCALEI_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] SCALEQ_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] ZCOUNT_OFS = 8'h1C;

  // Control register fields
  localparam int CTRL_PRE_BIT    = 0;
  localparam int CTRL_WIN_BIT    = 1;
  localparam int CTRL_FFT_BIT    = 2;
  localparam int CTRL_LOG_BIT    = 3;
  localparam int CTRL_ZERO_BIT   = 4;
  localparam int CTRL_MODE_LSB   = 5;
  localparam int CTRL_SIZE_LSB   = 8;
  localparam int CTRL_START_BIT  = 31;
  localparam int STAT_INDEX_LSB  = 16;

  // Reset values
  localparam logic [SAMPLE_W-1:0] THRESH_RST = 24'hFFFFFF;
  localparam logic [SCALE_W-1:0]  SCALE_RST  = 21'h010000;

  // Complex multiplier modes
  typedef enum logic [2:0] {
    MODE_BYPASS  = 3'h0,
    MODE_FSHIFT  = 3'h1,
    MODE_DFT     = 3'h2,
    MODE_STITCH  = 3'h3,
    MODE_MAGSQ   = 3'h4,
    MODE_SCALAR  = 3'h5,
    MODE_VECTOR1 = 3'h6,
    MODE_VECTOR2 = 3'h7
  } fpz_mode_t;
endpackage

/* hw/fpz_fifo.sv */
module fpz_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PTR_W:0]   cnt_reg, cnt_next;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready_o  = (cnt_reg != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and storage update
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_i;
      wr_next = (wr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PTR_W'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Storage holds no reset; only the pointers and the count do
  always_ff @(posedge clk_i) begin
    mem_reg <= mem_next;
    if (sys_rst_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

/* hw/fpz_twiddle.sv */
module fpz_twiddle (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              sys_rst_i,
  // Lookup request
  input  wire logic                              hold_i,
  input  wire logic [fpz_pkg::PHASE_W-1:0]       index_i,
  // Registered cos and sin
  output logic signed [fpz_pkg::TWID_W-1:0]      cos_o,
  output logic signed [fpz_pkg::TWID_W-1:0]      sin_o
);
  localparam int QW = fpz_pkg::QUARTER_W;

  // Quarter-wave cosine, folded to cover the full circle
  function automatic logic [fpz_pkg::TWID_W-1:0] qcos(input int k);
    real ang;
    ang = 6.283185307179586 * real'(k) / real'(fpz_pkg::TWID_POINTS);
    return fpz_pkg::TWID_W'($rtoi($cos(ang) * real'(1 << fpz_pkg::TWID_FRAC) + 0.5));
  endfunction

  logic [fpz_pkg::TWID_W-1:0] tab [fpz_pkg::QUARTER+1];
  for (genvar k = 0; k <= fpz_pkg::QUARTER; k++) begin : g_tab
    assign tab[k] = qcos(k);
  end

  logic [1:0]                        quad;
  logic [QW:0]                       r, rc;
  logic signed [fpz_pkg::TWID_W-1:0] a, b, cos_next, sin_next;

  // Quadrant folding of the 14-bit phase
  always_comb begin
    quad = index_i[fpz_pkg::PHASE_W-1 -: 2];
    r    = {1'b0, index_i[QW-1:0]};
    rc   = (QW+1)'(fpz_pkg::QUARTER) - r;
    a    = tab[r];
    b    = tab[rc];
    case (quad)
      2'h0: begin
        cos_next = a;
        sin_next = b;
      end
      2'h1: begin
        cos_next = -b;
        sin_next = a;
      end
      2'h2: begin
        cos_next = -a;
        sin_next = -b;
      end
      default: begin
        cos_next = b;
        sin_next = -a;
      end
    endcase
    // Keep the pair aligned with a stalled stage one
    if (hold_i) begin
      cos_next = cos_o;
      sin_next = sin_o;
    end
  end

  // Registered twiddle pair
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cos_o <= '0;
      sin_o <= '0;
    end else begin
      cos_o <= cos_next;
      sin_o <= sin_next;
    end
  end
endmodule

/* dv/fpz_preproc_monitor.sv */
module fpz_preproc_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  // Streams and stage enables
  input wire logic        in_valid_i,
  input wire logic        in_ready_o,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [23:0] out_real_o,
  input wire logic [23:0] out_imag_o,
  input wire logic        window_enable_o,
  input wire logic        fft_enable_o,
  input wire logic        logmag_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single domain, so clock and reset once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  thresh_width_a: assert property ($past(reg_read_i && reg_addr_i == 8'h04) |-> reg_rdata_o[31:24] == 8'h0)
    else $error("threshold wider than 24 bits");
  unmapped_read_a: assert property ($past(reg_read_i && reg_addr_i > 8'h1F) |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable({out_real_o, out_imag_o}))
    else $error("output dropped under stall");
  empty_ready_a: assert property (!out_valid_o |-> in_ready_o)
    else $error("refused while output empty");
  pass_latency_a: assert property (in_valid_i && in_ready_o && !out_valid_o |-> ##[1:3] out_valid_o)
    else $error("sample late to output");
  stage_load_a: assert property (reg_write_i && reg_addr_i == 8'h00
    |=> {logmag_enable_o, fft_enable_o, window_enable_o} == $past(reg_wdata_i[3:1]))
    else $error("stage enables not loaded");
  stage_keep_a: assert property (!(reg_write_i && reg_addr_i == 8'h00)
    |=> $stable({logmag_enable_o, fft_enable_o, window_enable_o}))
    else $error("stage enables moved");
  reset_idle_a: assert property ($fell(sys_rst_i) |-> !out_valid_o && in_ready_o && !fft_enable_o)
    else $error("not idle after reset");
endmodule

bind fpz_preproc fpz_preproc_monitor fpz_preproc_monitor_inst (.*);

/* dv/fpz_sink.sv */
module fpz_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Hold off, or random back-pressure
  input wire logic stall_i,
  input wire logic slow_i,
  // Accept toward the block
  output logic     ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 89;

  // Ready moves only after an edge, as a windowing stage would
  always @(posedge clk_i)
    ready_o <= !sys_rst_i && !stall_i && (!slow_i || $random(seed) % 3 != 0);
endmodule

/* dv/fpz_preproc_bench.sv */
module fpz_preproc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Design ports
  logic clk_i = 1'h0, sys_rst_i = 1'h1, reg_write_i = 1'h0, reg_read_i = 1'h0, in_valid_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [23:0] in_real_i = 24'h0, in_imag_i = 24'h0, out_real_o, out_imag_o;
  logic in_ready_o, out_valid_o, out_ready_i, window_enable_o, fft_enable_o, logmag_enable_o;
  // Bench state
  logic stall = 1'h0, slow = 1'h0;
  logic [47:0] exp_q[$];
  int seed = 89, n_fail = 0, checks = 0, cyc = 0, nidx = 0;
  int mode_c, pre_c, zen_c, thr_c, step_c, zc, cnt_c = 4096, sz_c = 0;

  fpz_preproc fpz_preproc_inst (.*);
  fpz_sink fpz_sink_inst (.clk_i, .sys_rst_i, .stall_i(stall), .slow_i(slow), .ready_o(out_ready_i));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cut a hang short; the run needs only a few hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Samples taken by the far side must match the model, in order
  always @(posedge clk_i) begin
    if (!sys_rst_i && out_valid_o === 1'h1 && out_ready_i === 1'h1) begin
      if (exp_q.size() == 0)
        chk(1'h0, "extra sample");
      else
        chk({out_real_o, out_imag_o} === exp_q.pop_front(), "sample value");
    end
  end

  // Reference: approximate magnitude, zeroing, then the multiplier
  function automatic logic [47:0] model(input int re, im, n);
    int a, b, mx, mn;
    a = re < 0 ? -re : re;
    b = im < 0 ? -im : im;
    mx = a > b ? a : b;
    mn = a > b ? b : a;
    mx = mx > mx - mx / 8 + mn / 2 ? mx : mx - mx / 8 + mn / 2;
    if (pre_c && zen_c && mx > thr_c) begin
      re = 0;
      im = 0;
      zc++;
    end
    // quarter turns only; DFT adds 2^(14-size) per iteration
    if (pre_c && (mode_c == 1 || mode_c == 2)) begin
      b = step_c + (mode_c == 2 ? (16384 >> sz_c) * (n / cnt_c) : 0);
      repeat ((b * (n % cnt_c) >> 12) & 3) begin
        a = re;
        re = -im;
        im = a;
      end
    end
    if (pre_c && mode_c == 4) begin
      re = int'((longint'(re) * re + longint'(im) * im) >>> 23);
      im = 0;
    end
    return {re[23:0], im[23:0]};
  endfunction

  // Random parts kept small so no product saturates
  function automatic logic [23:0] rs();
    return 24'($random(seed) >>> 10);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'h1;
    @(posedge clk_i);
    reg_write_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_read_i <= 1'h1;
    @(posedge clk_i);
    reg_read_i <= 1'h0;
    @(negedge clk_i);
    chk(reg_rdata_o === e, "register read");
    @(posedge clk_i);
  endtask

  task automatic drain();
    for (int k = 0; k < 100 && exp_q.size() != 0; k++)
      @(posedge clk_i);
    chk(exp_q.size() == 0, "not drained");
  endtask

  // Restart with a new set; in-flight samples are drained first
  task automatic cfg(input int m, p, z, t, s);
    logic [2:0] e;
    drain();
    e = 3'($random(seed));
    mode_c = m;
    pre_c = p;
    zen_c = z;
    thr_c = t;
    step_c = s;
    nidx = 0;
    zc = 0;
    wr(8'h08, 32'(s));
    wr(8'h04, 32'(t));
    wr(8'h00, {1'h1, 19'h0, 4'(sz_c), 3'(m), 1'(z), e, 1'(p)});
    chk({logmag_enable_o, fft_enable_o, window_enable_o} === e, "stage enables");
  endtask

  // Valid stays up across back-to-back samples
  task automatic send1(input logic [23:0] i, q);
    in_valid_i <= 1'h1;
    in_real_i <= i;
    in_imag_i <= q;
    do @(posedge clk_i); while (in_ready_o !== 1'h1);
    exp_q.push_back(model($signed(i), $signed(q), nidx));
    nidx++;
  endtask

  task automatic stream(input int cnt);
    send1(24'(thr_c), 24'h0);
    send1(24'(thr_c + 1), 24'h0);
    send1(24'h3FFFFF, 24'hC00001);
    repeat (cnt) send1(rs(), rs());
    in_valid_i <= 1'h0;
    drain();
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    rd(8'h04, 32'h00FFFFFF);
    rd(8'h10, 32'h00010000);
    rd(8'h24, 32'h0);
    wr(8'h04, 32'hFF123456);
    rd(8'h04, 32'h00123456);
    wr(8'h0C, 32'h00000FFF);
    rd(8'h0C, 32'h00000FFF);
    $display("registers done");
    for (int m = 0; m < 8; m++) begin
      slow <= m[0];
      cfg(m, 1, 1, 24'h200000, 4096);
      stream(20);
      rd(8'h1C, 32'(zc));
      rd(8'h18, {2'h0, 14'(nidx * step_c), 4'h0, 12'(nidx)});
      $display("mode %0d done", m);
    end
    cfg(0, 1, 0, 24'h000010, 0);
    stream(10);
    cfg(1, 1, 1, 24'hFFFFFF, 8192);
    stream(10);
    cfg(1, 0, 1, 24'h000010, 4096);
    stream(10);
    // DFT walk: four-sample iterations, frequency up a quarter turn each
    wr(8'h0C, 32'h00000003);
    cnt_c = 4;
    sz_c = 2;
    cfg(2, 1, 0, 24'hFFFFFF, 0);
    stream(13);
    $display("enables done");
    // Far side holds off: buffer fills, refuses, then drains in order
    stall <= 1'h1;
    fork
      repeat (10) send1(rs(), rs());
    join_none
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    chk(in_ready_o === 1'h0 && exp_q.size() >= 4, "buffer not full");
    @(posedge clk_i);
    stall <= 1'h0;
    wait fork;
    in_valid_i <= 1'h0;
    drain();
    $display("buffer done");
    report_and_stop();
  end
endmodule
